// File: hdl/psm_consts.svh
// Purpose: constants for the pin strap and GPIO mux block
// Assumes: included by bare name; definitions only
// Notes: addresses are 7-bit management bus addresses
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// Fallback bus addresses used when strap pins are not bonded out
`define PSM_CFG_MEM_FALLBACK 7'h50
`define PSM_TARGET_FALLBACK 7'h77

// Reference frequency strap codes
`define PSM_REF_CODE_100 1'h0
`define PSM_REF_CODE_125 1'h1

// Pin and port counts
`define PSM_NUM_GPIO 7
`define PSM_NUM_PORTS 6
`define PSM_LANES_PER_PORT 4
`define PSM_UPSTREAM_PORT 0

// GPIO indices carrying alternate functions, and the one plain pin
`define PSM_PIN_DS_TWO_RST 0
`define PSM_PIN_DS_FOUR_RST 1
`define PSM_PIN_IRQ_FIRST 2
`define PSM_PIN_PLAIN 6

`endif

// File: hdl/psm_gpio_cell.sv
// Purpose: one general purpose pin with an optional alternate function
// Assumes: pin input synchronous to clk; coreClear is a synchronous clear
// Notes: output enable is low while the cell drives the pin
module psm_gpio_cell #(
	parameter psm_pkg::psm_alt_kind_type ALT_KIND = psm_pkg::PSM_ALT_NONE
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic coreClear,
	input wire logic cfgWrite,
	input wire logic cfgAltSel,
	input wire logic cfgDirOut,
	input wire logic cfgOutValue,
	input wire logic altDriveN,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOeN,
	output logic inValue,
	output logic altInN
);

	logic altSel;
	logic dirOut;
	logic outValue;

	// Per-pin setting; plain GPIO input after any reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			altSel <= 1'b0;
			dirOut <= 1'b0;
			outValue <= 1'b0;
		end else if (coreClear) begin
			altSel <= 1'b0;
			dirOut <= 1'b0;
			outValue <= 1'b0;
		end else if (cfgWrite) begin
			altSel <= (ALT_KIND != psm_pkg::PSM_ALT_NONE) && cfgAltSel;
			dirOut <= cfgDirOut;
			outValue <= cfgOutValue;
		end
	end

	// Pin drive: alternate output, alternate input, or plain GPIO
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pinOut <= 1'b1;
			pinOeN <= 1'b1;
		end else if (altSel && ALT_KIND == psm_pkg::PSM_ALT_OUT) begin
			pinOut <= altDriveN;
			pinOeN <= 1'b0;
		end else if (altSel && ALT_KIND == psm_pkg::PSM_ALT_IN) begin
			pinOut <= 1'b1;
			pinOeN <= 1'b1;
		end else begin
			pinOut <= outValue;
			pinOeN <= ~dirOut;
		end
	end

	// Input side; an unselected interrupt reads negated (high)
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			inValue <= 1'b0;
			altInN <= 1'b1;
		end else begin
			inValue <= pinIn;
			altInN <= (altSel && ALT_KIND == psm_pkg::PSM_ALT_IN) ? pinIn : 1'b1;
		end
	end

endmodule : psm_gpio_cell

// File: hdl/psm_pkg.sv
// Purpose: shared types for the pin strap and GPIO mux block
// Assumes: nothing is imported; users write psm_pkg::name
// Notes: numeric constants live in psm_consts.svh
package psm_pkg;

	// What a pin offers when its alternate function is selected
	typedef enum {
		PSM_ALT_NONE,
		PSM_ALT_OUT,
		PSM_ALT_IN
	} psm_alt_kind_type;

	// Decoded reference clock frequency
	typedef enum logic {
		PSM_REF_100MHZ,
		PSM_REF_125MHZ
	} psm_ref_freq_type;

endpackage : psm_pkg

// File: hdl/psm_strap_gpio_mux.sv
// Purpose: strap capture, reset framing and GPIO 0..6 alternate-function mux
// Assumes: all inputs but arst_n synchronous to clk (200 MHz); straps static after reset
// Notes: pins missing on the small package are modelled by parameters
`include "psm_consts.svh"

module psm_strap_gpio_mux #(
	parameter bit HAS_FREQ_PIN = 1'b1,
	parameter bit HAS_ADDR_PINS = 1'b1,
	parameter int NUM_PORTS = `PSM_NUM_PORTS,
	parameter int LANES_PER_PORT = `PSM_LANES_PER_PORT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fundamentalResetN,
	input wire logic refFreqSelect,
	input wire logic [3:0] cfgMemAddrStraps,
	input wire logic [3:0] targetAddrStraps,
	input wire logic cfgWrite,
	input wire logic [`PSM_NUM_GPIO-1:0] gpioAltSel,
	input wire logic [`PSM_NUM_GPIO-1:0] gpioDirOut,
	input wire logic [`PSM_NUM_GPIO-1:0] gpioOutValue,
	input wire logic downstreamTwoResetReq,
	input wire logic downstreamFourResetReq,
	input wire logic [`PSM_NUM_GPIO-1:0] gpioPinIn,
	output logic [`PSM_NUM_GPIO-1:0] gpioPinOut,
	output logic [`PSM_NUM_GPIO-1:0] gpioPinOeN,
	output logic [`PSM_NUM_GPIO-1:0] gpioInValue,
	output logic expanderIrqZeroN,
	output logic expanderIrqOneN,
	output logic expanderIrqTwoN,
	output logic expanderIrqThreeN,
	output logic refFreq125,
	output logic [6:0] cfgMemBusAddr,
	output logic [6:0] targetBusAddr,
	output logic strapsValid,
	output logic coreResetN,
	output logic linkFundResetN,
	output logic [NUM_PORTS-1:0] upstreamPortMask,
	output logic [NUM_PORTS*LANES_PER_PORT-1:0] laneEnable
);

	logic rstMetaN;
	logic rstN;
	logic coreClear;
	logic dsTwoDriveN;
	logic dsFourDriveN;
	logic [`PSM_NUM_GPIO-1:0] altDriveN;
	logic [`PSM_NUM_GPIO-1:0] altInN;
	logic [6:0] cfgFallback;
	logic [6:0] tgtFallback;
	psm_pkg::psm_ref_freq_type refFreq;

	assign cfgFallback = `PSM_CFG_MEM_FALLBACK;
	assign tgtFallback = `PSM_TARGET_FALLBACK;

	// Reset release through two flops; the first flop feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMetaN <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMetaN <= 1'b1;
			rstN <= rstMetaN;
		end
	end

	// Fundamental reset is low-active, so low clears the pin cells and samples the straps
	assign coreClear = !fundamentalResetN;

	// Reset outputs to core logic and serial links follow the fundamental reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			coreResetN <= 1'b0;
			linkFundResetN <= 1'b0;
		end else begin
			coreResetN <= fundamentalResetN;
			linkFundResetN <= fundamentalResetN;
		end
	end

	// Frequency strap follows the pin while reset is held, frozen afterwards
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			refFreq <= psm_pkg::PSM_REF_100MHZ;
		end else if (coreClear) begin
			if (HAS_FREQ_PIN && refFreqSelect == `PSM_REF_CODE_125) begin
				refFreq <= psm_pkg::PSM_REF_125MHZ;
			end else begin
				refFreq <= psm_pkg::PSM_REF_100MHZ;
			end
		end
	end

	// PLL reference select; sampling only under reset relies on a steady strap
	assign refFreq125 = (refFreq == psm_pkg::PSM_REF_125MHZ);

	// Address straps: free-running sample under reset, held after release
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cfgMemBusAddr <= `PSM_CFG_MEM_FALLBACK;
			targetBusAddr <= `PSM_TARGET_FALLBACK;
		end else if (coreClear) begin
			if (HAS_ADDR_PINS) begin
				cfgMemBusAddr <= {cfgFallback[6:5], cfgMemAddrStraps, cfgFallback[0]};
				targetBusAddr <= {tgtFallback[6], targetAddrStraps[3], tgtFallback[4],
					targetAddrStraps[2:0], tgtFallback[0]};
			end else begin
				cfgMemBusAddr <= `PSM_CFG_MEM_FALLBACK;
				targetBusAddr <= `PSM_TARGET_FALLBACK;
			end
		end
	end

	// Straps flagged valid one cycle after fundamental reset is high; the flag drops again during every fundamental reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			strapsValid <= 1'b0;
		end else begin
			strapsValid <= fundamentalResetN;
		end
	end

	// Port roles and lane enables; lanes idle while the links are in reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			upstreamPortMask <= '0;
			laneEnable <= '0;
		end else begin
			upstreamPortMask <= NUM_PORTS'(1) << `PSM_UPSTREAM_PORT;
			laneEnable <= {(NUM_PORTS*LANES_PER_PORT){fundamentalResetN}};
		end
	end

	// Downstream resets: asserted (low) on request or during fundamental reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			dsTwoDriveN <= 1'b0;
			dsFourDriveN <= 1'b0;
		end else begin
			dsTwoDriveN <= fundamentalResetN && !downstreamTwoResetReq;
			dsFourDriveN <= fundamentalResetN && !downstreamFourResetReq;
		end
	end

	// Alternate output sources; only pins 0 and 1 use them
	always_comb begin
		altDriveN = '1;
		altDriveN[`PSM_PIN_DS_TWO_RST] = dsTwoDriveN;
		altDriveN[`PSM_PIN_DS_FOUR_RST] = dsFourDriveN;
	end

	// One cell per pin, alternate kind chosen by index
	for (genvar i = 0; i < `PSM_NUM_GPIO; i++) begin : g_pin
		localparam psm_pkg::psm_alt_kind_type KIND =
			(i <= `PSM_PIN_DS_FOUR_RST) ? psm_pkg::PSM_ALT_OUT :
			(i < `PSM_PIN_PLAIN) ? psm_pkg::PSM_ALT_IN : psm_pkg::PSM_ALT_NONE;
		psm_gpio_cell #(
			.ALT_KIND(KIND)
		) u_cell (
			.clk(clk),
			.rstN(rstN),
			.coreClear(coreClear),
			.cfgWrite(cfgWrite),
			.cfgAltSel(gpioAltSel[i]),
			.cfgDirOut(gpioDirOut[i]),
			.cfgOutValue(gpioOutValue[i]),
			.altDriveN(altDriveN[i]),
			.pinIn(gpioPinIn[i]),
			.pinOut(gpioPinOut[i]),
			.pinOeN(gpioPinOeN[i]),
			.inValue(gpioInValue[i]),
			.altInN(altInN[i])
		);
	end

	// Expander interrupts come straight from the cell flops
	assign expanderIrqZeroN = altInN[`PSM_PIN_IRQ_FIRST];
	assign expanderIrqOneN = altInN[`PSM_PIN_IRQ_FIRST+1];
	assign expanderIrqTwoN = altInN[`PSM_PIN_IRQ_FIRST+2];
	assign expanderIrqThreeN = altInN[`PSM_PIN_IRQ_FIRST+3];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	property p_ref_sample;
		!fundamentalResetN |=> refFreq125 == (HAS_FREQ_PIN && $past(refFreqSelect));
	endproperty
	a_ref_sample: assert property (p_ref_sample) else $error("freq strap decode wrong");

	property p_ref_fixed;
		!HAS_FREQ_PIN |-> !refFreq125;
	endproperty
	a_ref_fixed: assert property (p_ref_fixed) else $error("missing pin not 100 MHz");

	property p_cfg_addr;
		!fundamentalResetN && HAS_ADDR_PINS |=>
			cfgMemBusAddr[4:1] == $past(cfgMemAddrStraps) && cfgMemBusAddr[6:5] == 2'h2;
	endproperty
	a_cfg_addr: assert property (p_cfg_addr) else $error("config memory address wrong");

	property p_cfg_fallback;
		!HAS_ADDR_PINS |-> cfgMemBusAddr == `PSM_CFG_MEM_FALLBACK;
	endproperty
	a_cfg_fallback: assert property (p_cfg_fallback) else $error("config fallback wrong");

	property p_tgt_addr;
		!fundamentalResetN && HAS_ADDR_PINS |=>
			{targetBusAddr[5], targetBusAddr[3:1]} == $past(targetAddrStraps);
	endproperty
	a_tgt_addr: assert property (p_tgt_addr) else $error("target address wrong");

	property p_tgt_fallback;
		!HAS_ADDR_PINS |-> targetBusAddr == `PSM_TARGET_FALLBACK;
	endproperty
	a_tgt_fallback: assert property (p_tgt_fallback) else $error("target fallback wrong");

	property p_strap_hold;
		fundamentalResetN |=> $stable(cfgMemBusAddr) && $stable(targetBusAddr) && $stable(refFreq125);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap moved after reset");

	property p_fund_reset;
		!fundamentalResetN |=> !coreResetN && !linkFundResetN && laneEnable == '0;
	endproperty
	a_fund_reset: assert property (p_fund_reset) else $error("fundamental reset not applied");

	property p_irq_pin;
		!expanderIrqZeroN |-> $past(!gpioPinIn[`PSM_PIN_IRQ_FIRST]);
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt without low pin");

	property p_gpio_default;
		!fundamentalResetN ##1 !cfgWrite |=> &gpioPinOeN;
	endproperty
	a_gpio_default: assert property (p_gpio_default) else $error("pins driven after reset");

	c_strap_capture: cover property (!fundamentalResetN ##1 fundamentalResetN ##1 strapsValid);
	c_ds_two_reset: cover property (!gpioPinOeN[`PSM_PIN_DS_TWO_RST] && !gpioPinOut[0]);
	c_irq_seen: cover property (!expanderIrqThreeN);

endmodule : psm_strap_gpio_mux

// File: tb/psm_far_side.sv
// Purpose: pin-side model of downstream devices and I/O expanders
// Assumes: a pin with its output enable high is not driven by the switch
// Notes: undriven pins take the level the bench commands, never a stale one
module psm_far_side (
	input wire logic [6:0] pinOut,
	input wire logic [6:0] pinOeN,
	input wire logic [6:0] extLevel,
	output logic [6:0] pinIn,
	output logic [1:0] dsResetSeenN
);
	timeunit 1ns;
	timeprecision 1ps;

	// Wire level: switch drive wins, else expander or board level
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			pinIn[i] = pinOeN[i] ? extLevel[i] : pinOut[i];
		end
	end

	// Downstream ports 2 and 4 see their reset asserted at logic zero
	assign dsResetSeenN = {pinIn[1], pinIn[0]};
endmodule : psm_far_side

// File: tb/tb_top.sv
// Purpose: self-checking bench for strap capture and GPIO mux
// Assumes: inputs change at the falling edge, outputs settle by then
// Notes: a second instance models the small package with no strap pins
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic fundamentalResetN = 1'b0;
	logic refFreqSelect = 1'b0;
	logic [3:0] cfgMemAddrStraps = 4'h0;
	logic [3:0] targetAddrStraps = 4'h0;
	logic cfgWrite = 1'b0;
	logic [6:0] gpioAltSel = 7'h00, gpioDirOut = 7'h00, gpioOutValue = 7'h00;
	logic downstreamTwoResetReq = 1'b0, downstreamFourResetReq = 1'b0;
	logic [6:0] extLevel = 7'h7F;
	logic [6:0] gpioPinIn, gpioPinOut, gpioPinOeN, gpioInValue;
	logic expanderIrqZeroN, expanderIrqOneN, expanderIrqTwoN, expanderIrqThreeN;
	logic refFreq125, strapsValid, coreResetN, linkFundResetN, smallFreq;
	logic [6:0] cfgMemBusAddr, targetBusAddr, smallCfg, smallTgt;
	logic [5:0] upstreamPortMask;
	logic [23:0] laneEnable;
	logic [1:0] dsSeenN;
	logic [3:0] irqsN;
	int failures = 0, n_checks = 0, cycles = 0;

	psm_strap_gpio_mux dut (.*);
	psm_strap_gpio_mux #(.HAS_FREQ_PIN(1'b0), .HAS_ADDR_PINS(1'b0)) dut_small (
		.*, .gpioPinOut(), .gpioPinOeN(), .gpioInValue(), .expanderIrqZeroN(),
		.expanderIrqOneN(), .expanderIrqTwoN(), .expanderIrqThreeN(),
		.refFreq125(smallFreq), .cfgMemBusAddr(smallCfg), .targetBusAddr(smallTgt),
		.strapsValid(), .coreResetN(), .linkFundResetN(), .upstreamPortMask(),
		.laneEnable());
	psm_far_side far (.pinOut(gpioPinOut), .pinOeN(gpioPinOeN), .extLevel(extLevel),
		.pinIn(gpioPinIn), .dsResetSeenN(dsSeenN));

	// Interrupt outputs gathered, pin 5 down to pin 2
	assign irqsN = {expanderIrqThreeN, expanderIrqTwoN, expanderIrqOneN, expanderIrqZeroN};

	// Free-running 200 MHz clock
	always #2.5 clk = ~clk;

	// Hang guard, well above the roughly 55 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask : ticks

	// One config write; pins reflect it one edge after it is taken
	task automatic configure(input logic [6:0] alt, input logic [6:0] dir, input logic [6:0] val);
		gpioAltSel = alt;
		gpioDirOut = dir;
		gpioOutValue = val;
		cfgWrite = 1'b1;
		ticks(1);
		cfgWrite = 1'b0;
		ticks(2);
	endtask : configure

	// Fundamental reset with straps set; address straps then move, frequency strap stays
	task automatic strap_cycle(input logic f, input logic [3:0] m, input logic [3:0] s);
		fundamentalResetN = 1'b0;
		refFreqSelect = f;
		cfgMemAddrStraps = m;
		targetAddrStraps = s;
		ticks(3);
		check("coreResetN", coreResetN, 1'b0);
		check("laneEnable", laneEnable, 24'h000000);
		fundamentalResetN = 1'b1;
		ticks(2);
		cfgMemAddrStraps = ~m;
		targetAddrStraps = ~s;
		ticks(2);
		check("refFreq125", refFreq125, f);
		check("cfgMemBusAddr", cfgMemBusAddr, {1'b1, 1'b0, m, 1'b0});
		check("targetBusAddr", targetBusAddr, {1'b1, s[3], 1'b1, s[2:0], 1'b1});
		check("smallFreq", smallFreq, 1'b0);
		check("smallCfg", smallCfg, 7'h50);
		check("smallTgt", smallTgt, 7'h77);
		check("ready", {strapsValid, coreResetN, linkFundResetN}, 3'h7);
		check("upstreamPortMask", upstreamPortMask, 6'h01);
		check("laneEnable", laneEnable, 24'hFFFFFF);
		check("gpioPinOeN", gpioPinOeN, 7'h7F);
	endtask : strap_cycle

	task automatic complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		ticks(3);
		arst_n = 1'b1;
		ticks(3);
		strap_cycle(1'b0, 4'hA, 4'h5);
		strap_cycle(1'b1, 4'h5, 4'hA);
		configure(7'h00, 7'h7F, 7'h55);
		check("gpioPinOut", gpioPinOut, 7'h55);
		check("gpioPinOeN", gpioPinOeN, 7'h00);
		configure(7'h00, 7'h00, 7'h7F);
		extLevel = 7'h2A;
		ticks(2);
		check("gpioPinOeN", gpioPinOeN, 7'h7F);
		check("gpioInValue", gpioInValue, 7'h2A);
		check("irqs", irqsN, 4'hF);
		// Alternate on all pins; pin 6 has none and must stay a GPIO output
		configure(7'h7F, 7'h40, 7'h40);
		downstreamTwoResetReq = 1'b1;
		extLevel = 7'h2B;
		ticks(3);
		check("dsSeenN", dsSeenN, 2'h2);
		check("gpioPinOeN", gpioPinOeN[1:0], 2'h0);
		check("irqs", irqsN, 4'hA);
		check("pin6", {gpioPinOeN[6], gpioPinOut[6]}, 2'h1);
		downstreamTwoResetReq = 1'b0;
		downstreamFourResetReq = 1'b1;
		extLevel = 7'h14;
		ticks(3);
		check("dsSeenN", dsSeenN, 2'h1);
		check("irqs", irqsN, 4'h5);
		// Fundamental reset must drop every pin back to a plain input
		strap_cycle(1'b0, 4'h3, 4'hC);
		// Asynchronous reset in mid-run, then a clean release and recapture
		arst_n = 1'b0;
		ticks(1);
		check("cfgMemBusAddr", cfgMemBusAddr, 7'h50);
		check("coreResetN", coreResetN, 1'b0);
		check("strapsValid", strapsValid, 1'b0);
		check("irqs", irqsN, 4'hF);
		arst_n = 1'b1;
		ticks(3);
		strap_cycle(1'b1, 4'hC, 4'h3);
		complete_run();
	end
endmodule : tb_top
